/* File: design/eip_pkg.sv */
// constants and types for the external interrupt pin unit
package eip_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [11:0] EIP_STATUS_CONTROL_ADDR = 12'h000;
  localparam logic [11:0] EIP_SECOND_CONFIG_ADDR  = 12'h004;
  localparam logic [11:0] EIP_PORT_A_DATA_ADDR    = 12'h008;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int EIP_MODE_BIT    = 0;
  localparam int EIP_MASK_BIT    = 1;
  localparam int EIP_ACK_BIT     = 2;
  localparam int EIP_FLAG_BIT    = 3;
  localparam int EIP_ENABLE_BIT  = 0;
  localparam int EIP_PUD_BIT     = 1;
  localparam int EIP_PIN_PORT_A  = 2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic EIP_MODE_RESET   = 1'b0;
  localparam logic EIP_MASK_RESET   = 1'b0;
  localparam logic EIP_ENABLE_RESET = 1'b0;
  localparam logic EIP_PUD_RESET    = 1'b0;

  // ------------------------------------------------------------
  // bus encodings
  // ------------------------------------------------------------
  localparam logic [1:0]  EIP_HTRANS_NONSEQ = 2'h2;
  localparam logic        EIP_HRESP_OKAY    = 1'b0;
  localparam logic [31:0] EIP_READ_ZERO     = 32'h0000_0000;

  // captured address phase of one bus transfer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } eip_bus_cmd_type;

endpackage

/* File: design/eip_top.sv */
// external interrupt pin unit: pin latch, control registers, ahb-lite slave
`timescale 1ns/1ps
`default_nettype none

module eip_top
  import eip_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // interrupt pin and port a
  input  wire logic              irq_pin_n,
  input  wire logic [7:0]        port_a_bit_in,
  output logic                   pin_pullup_enable,
  output logic                   pin_is_interrupt,
  output logic                   branch_pin_level,
  // processor side
  input  wire logic              vector_fetch_ack,
  input  wire logic              break_state,
  input  wire logic              break_clear_enable,
  output logic                   irq_request,
  output logic                   wake_request
);
  import eip_pkg::*;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (ADDR_W < 12) begin : g_addr_check
    $error("eip_top: ADDR_W must be at least 12");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic            pin_meta_reg;
  logic            pin_sync_reg;
  logic            pin_prev_reg;
  logic            latch_reg;
  logic            latch_next;
  logic            ack_seen_reg;
  logic            ack_seen_next;
  logic            mode_reg;
  logic            mask_reg;
  logic            enable_reg;
  logic            pud_reg;
  logic [31:0]     hrdata_reg;
  logic [31:0]     read_value;
  eip_bus_cmd_type cmd_reg;
  logic            fall_seen;
  logic            pin_low;
  logic            trigger;
  logic            sw_write_ctl;
  logic            sw_ack;
  logic            status_frozen;
  logic            any_ack;

  // ------------------------------------------------------------
  // pin synchroniser and edge detect
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= irq_pin_n;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_low   = ~pin_sync_reg;
  assign fall_seen = pin_prev_reg & ~pin_sync_reg;
  // the unit looks at the pin only when the function owns it
  assign trigger   = enable_reg & (fall_seen | (mode_reg & pin_low));

  // ------------------------------------------------------------
  // acknowledge sources
  // ------------------------------------------------------------
  assign sw_write_ctl  = cmd_reg.valid & cmd_reg.write
                         & (cmd_reg.addr == EIP_STATUS_CONTROL_ADDR);
  // status is protected during break unless clearing is allowed
  assign status_frozen = break_state & ~break_clear_enable;
  assign sw_ack        = sw_write_ctl & hwdata[EIP_ACK_BIT]
                         & ~status_frozen;
  assign any_ack       = vector_fetch_ack | sw_ack;

  // ------------------------------------------------------------
  // request latch
  // ------------------------------------------------------------
  always_comb begin
    latch_next    = latch_reg;
    ack_seen_next = ack_seen_reg;
    if (trigger & fall_seen) begin
      // a new edge wins over any clear in the same cycle
      latch_next    = 1'b1;
      ack_seen_next = 1'b0;
    end else if (trigger & ~latch_reg) begin
      latch_next    = 1'b1;
    end else if (!mode_reg) begin
      if (any_ack) begin
        latch_next    = 1'b0;
      end
      ack_seen_next = 1'b0;
    end else begin
      // two-step clear: acknowledge and pin high, in either order
      if (latch_reg & (any_ack | ack_seen_reg) & ~pin_low & ~status_frozen) begin
        latch_next    = 1'b0;
        ack_seen_next = 1'b0;
      end else if (latch_reg & any_ack) begin
        ack_seen_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latch_reg    <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      latch_reg    <= latch_next;
      ack_seen_reg <= ack_seen_next;
    end
  end

  // ------------------------------------------------------------
  // control bits
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg <= EIP_MODE_RESET;
      mask_reg <= EIP_MASK_RESET;
    end else if (sw_write_ctl) begin
      mode_reg <= hwdata[EIP_MODE_BIT];
      mask_reg <= hwdata[EIP_MASK_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_reg <= EIP_ENABLE_RESET;
      pud_reg    <= EIP_PUD_RESET;
    end else if (cmd_reg.valid & cmd_reg.write
                 & (cmd_reg.addr == EIP_SECOND_CONFIG_ADDR)) begin
      enable_reg <= hwdata[EIP_ENABLE_BIT];
      pud_reg    <= hwdata[EIP_PUD_BIT];
    end
  end

  // ------------------------------------------------------------
  // outputs towards processor and pin
  // ------------------------------------------------------------
  // the request path has no clock gating, so it keeps working in wait and stop
  assign irq_request       = latch_reg & ~mask_reg;
  assign wake_request      = latch_reg & ~mask_reg;
  assign pin_is_interrupt  = enable_reg;
  assign pin_pullup_enable = ~pud_reg;
  assign branch_pin_level  = enable_reg ? pin_sync_reg : 1'b1;

  // ------------------------------------------------------------
  // ahb-lite slave: zero wait, read data registered at address phase
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_reg <= '0;
    end else if (hready) begin
      cmd_reg.valid <= hsel & (htrans == EIP_HTRANS_NONSEQ);
      cmd_reg.write <= hwrite;
      cmd_reg.addr  <= haddr[11:0];
    end else begin
      cmd_reg.valid <= 1'b0;
    end
  end

  always_comb begin
    read_value = EIP_READ_ZERO;
    if (haddr[11:0] == EIP_STATUS_CONTROL_ADDR) begin
      read_value[EIP_FLAG_BIT] = latch_reg;
      read_value[EIP_ACK_BIT]  = 1'b0;
      read_value[EIP_MASK_BIT] = mask_reg;
      read_value[EIP_MODE_BIT] = mode_reg;
    end else if (haddr[11:0] == EIP_SECOND_CONFIG_ADDR) begin
      read_value[EIP_ENABLE_BIT] = enable_reg;
      read_value[EIP_PUD_BIT]    = pud_reg;
    end else if (haddr[11:0] == EIP_PORT_A_DATA_ADDR) begin
      read_value[7:0] = port_a_bit_in;
      if (enable_reg) begin
        read_value[EIP_PIN_PORT_A] = 1'b0;
      end
    end
  end

  // unmapped addresses read zero and ignore writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata_reg <= EIP_READ_ZERO;
    end else if (hready & hsel & (htrans == EIP_HTRANS_NONSEQ) & ~hwrite) begin
      hrdata_reg <= read_value;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = EIP_HRESP_OKAY;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  mask_gate_a : assert property (mask_reg |-> !irq_request)
    else $error("masked request reached priority logic");
  unmask_pass_a : assert property (latch_reg && !mask_reg |-> irq_request && wake_request)
    else $error("unmasked latched request not presented");
  edge_set_a : assert property (enable_reg && fall_seen |=> latch_reg)
    else $error("falling edge did not set the latch");
  edge_ack_clear_a : assert property (!mode_reg && latch_reg && any_ack && !fall_seen
                                      |=> !latch_reg)
    else $error("edge mode acknowledge did not clear the latch");
  level_hold_a : assert property (mode_reg && latch_reg && pin_low |=> latch_reg)
    else $error("level mode request cleared while pin low");
  reset_clear_a : assert property (disable iff (1'b0) rst |=> !latch_reg && !mode_reg)
    else $error("reset left latch or mode set");
  flag_read_a : assert property (hready && hsel && htrans == EIP_HTRANS_NONSEQ && !hwrite
                                 && haddr[11:0] == EIP_STATUS_CONTROL_ADDR
                                 |=> hrdata[EIP_FLAG_BIT] == $past(latch_reg)
                                     && !hrdata[EIP_ACK_BIT])
    else $error("pending flag read wrong");
  break_keep_a : assert property (status_frozen && latch_reg && !vector_fetch_ack
                                  |=> latch_reg)
    else $error("latch changed during protected break");
  branch_level_a : assert property (!enable_reg |-> branch_pin_level)
    else $error("branch level not forced high while disabled");
  pullup_a : assert property (pud_reg |-> !pin_pullup_enable)
    else $error("pullup connected while disabled");
  idle_quiet_a : assert property (!enable_reg && !latch_reg |=> !latch_reg)
    else $error("disabled function set the latch");

  // ------------------------------------------------------------
  // assertions: latch set and clear paths
  // ------------------------------------------------------------
  level_set_a : assert property (enable_reg && mode_reg && pin_low
                                 |=> latch_reg)
    else $error("level mode low pin did not set the latch");

  sw_clear_a : assert property (!mode_reg && latch_reg && sw_ack && !fall_seen
                                |=> !latch_reg)
    else $error("software acknowledge did not clear the latch");

  fetch_clear_a : assert property (!mode_reg && latch_reg && vector_fetch_ack
                                   && !fall_seen |=> !latch_reg)
    else $error("vector fetch acknowledge did not clear the latch");

  edge_after_ack_a : assert property (enable_reg && fall_seen && sw_ack
                                      |=> latch_reg)
    else $error("edge beside an acknowledge was lost");

  ack_remember_a : assert property (mode_reg && latch_reg && any_ack && pin_low
                                    && !fall_seen |=> ack_seen_reg)
    else $error("acknowledge with pin low was forgotten");

  two_step_a : assert property (mode_reg && latch_reg && ack_seen_reg && !pin_low
                                && !status_frozen |=> !latch_reg)
    else $error("two-step clear did not complete");

  mask_keep_a : assert property (mask_reg && latch_reg && !any_ack && !ack_seen_reg
                                 |=> latch_reg)
    else $error("mask disturbed the latch");

  // ------------------------------------------------------------
  // assertions: break state
  // ------------------------------------------------------------
  frozen_step_a : assert property (mode_reg && status_frozen && latch_reg
                                   |=> latch_reg)
    else $error("two-step clear completed during protected break");

  break_clear_a : assert property (break_state && break_clear_enable && !mode_reg
                                   && latch_reg && sw_write_ctl && hwdata[EIP_ACK_BIT]
                                   && !fall_seen |=> !latch_reg)
    else $error("allowed break clear did not act");

  // ------------------------------------------------------------
  // assertions: registers, pin and outputs
  // ------------------------------------------------------------
  mode_write_a : assert property (sw_write_ctl
                                  |=> mode_reg == $past(hwdata[EIP_MODE_BIT]))
    else $error("mode bit write lost");

  mask_write_a : assert property (sw_write_ctl
                                  |=> mask_reg == $past(hwdata[EIP_MASK_BIT]))
    else $error("mask bit write lost");

  ctl_read_a : assert property (hready && hsel && htrans == EIP_HTRANS_NONSEQ && !hwrite
                                && haddr[11:0] == EIP_STATUS_CONTROL_ADDR
                                |=> hrdata[EIP_MASK_BIT] == $past(mask_reg)
                                    && hrdata[EIP_MODE_BIT] == $past(mode_reg))
    else $error("mask or mode read wrong");

  cfg_write_a : assert property (cmd_reg.valid && cmd_reg.write
                                 && cmd_reg.addr == EIP_SECOND_CONFIG_ADDR
                                 |=> enable_reg == $past(hwdata[EIP_ENABLE_BIT])
                                     && pud_reg == $past(hwdata[EIP_PUD_BIT]))
    else $error("configuration write lost");

  port_zero_a : assert property (hready && hsel && htrans == EIP_HTRANS_NONSEQ && !hwrite
                                 && haddr[11:0] == EIP_PORT_A_DATA_ADDR && enable_reg
                                 |=> !hrdata[EIP_PIN_PORT_A])
    else $error("shared port bit not read as zero");

  branch_follow_a : assert property (enable_reg
                                     |-> branch_pin_level == pin_sync_reg)
    else $error("branch level does not follow the pin");

  pullup_on_a : assert property (!pud_reg
                                 |-> pin_pullup_enable)
    else $error("pullup missing while allowed");

  wake_match_a : assert property (wake_request
                                  == irq_request)
    else $error("wake and request disagree");

  sync_chain_a : assert property (pin_sync_reg
                                  == $past(pin_meta_reg))
    else $error("second synchroniser stage skipped");

endmodule // eip_top

`default_nettype wire

/* File: tb/eip_pin_source.sv */
// model of the external source that pulls the interrupt pin low
`timescale 1ns/1ps
`default_nettype none

module eip_pin_source (
  // clock
  input  wire logic sys_clk,
  // request from the bench
  input  wire logic pull_low,
  // pin
  input  wire logic pullup_on,
  output logic      irq_pin_n
);
  logic float_q = 1'b0;

  // ----------------------------------------
  // released pin
  // ----------------------------------------
  // without the pullup a released pin wanders, so it never holds a tidy level
  always @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  assign irq_pin_n = pull_low ? 1'b0 : (pullup_on ? 1'b1 : float_q);
endmodule // eip_pin_source

`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the external interrupt pin unit
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import eip_pkg::*;
  localparam logic [11:0] SC = EIP_STATUS_CONTROL_ADDR;
  localparam logic [11:0] CF = EIP_SECOND_CONFIG_ADDR;
  localparam logic [11:0] PA = EIP_PORT_A_DATA_ADDR;
  typedef struct {logic [11:0] a; logic [31:0] wd, ex; logic pu, en;} eip_row_type;
  logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, pull_low = 0;
  logic vector_fetch_ack = 0, break_state = 0, break_clear_enable = 0;
  logic [11:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0, hrdata, rdv;
  logic [7:0]  port_a_bit_in = 8'hff;
  wire  logic  hready, hreadyout, hresp, irq_pin_n, pin_pullup_enable;
  wire  logic  pin_is_interrupt, branch_pin_level, irq_request, wake_request;
  int n_errors = 0, cmp_count = 0;
  eip_row_type rows [7] = '{
    '{SC, 32'h3, 32'h3, 1, 0}, '{SC, 32'h4, 32'h0, 1, 0},
    '{12'h00c, 32'hffff_ffff, 32'h0, 1, 0}, '{CF, 32'h2, 32'h2, 0, 0},
    '{PA, 32'h0, 32'hff, 0, 0}, '{CF, 32'h1, 32'h1, 1, 1}, '{PA, 32'h0, 32'hfb, 1, 1}};

  assign hready = hreadyout;
  always #50 sys_clk = ~sys_clk;

  eip_top eip_top_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_pin_n(irq_pin_n),
    .port_a_bit_in(port_a_bit_in), .pin_pullup_enable(pin_pullup_enable),
    .pin_is_interrupt(pin_is_interrupt), .branch_pin_level(branch_pin_level),
    .vector_fetch_ack(vector_fetch_ack), .break_state(break_state),
    .break_clear_enable(break_clear_enable), .irq_request(irq_request),
    .wake_request(wake_request));
  eip_pin_source eip_pin_source_i (.sys_clk(sys_clk), .pull_low(pull_low),
    .pullup_on(pin_pullup_enable), .irq_pin_n(irq_pin_n));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] ex, input string w);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, w, got, ex);
    end
  endtask
  task automatic chkb(input logic got, input logic ex, input string w);
    chk({31'h0, got}, {31'h0, ex}, w);
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  // one single word transfer; address phase held until hready, then data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= EIP_HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rdv = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] ex, input string w);
    xfer(1'b0, a, 32'h0);
    chk(rdv, ex, w);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // pin reaches the latch three edges after it moves, so four edges is settled
  task automatic pin(input logic low);
    @(posedge sys_clk) pull_low <= low;
    cyc(4);
  endtask
  task automatic vfa();
    @(posedge sys_clk) vector_fetch_ack <= 1'b1;
    @(posedge sys_clk) vector_fetch_ack <= 1'b0;
    cyc(2);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(3);
    @(posedge sys_clk) rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd);
      rdc(rows[i].a, rows[i].ex, "register readback");
      cyc(1);
      chkb(pin_pullup_enable, rows[i].pu, "pullup");
      chkb(pin_is_interrupt, rows[i].en, "pin function");
    end
    $display("register table done");
    wr(SC, 32'h4);
    pin(1);
    chkb(irq_request, 1, "edge sets");
    chkb(wake_request, 1, "wake");
    rdc(SC, 32'h8, "pending flag");
    vfa();
    chkb(irq_request, 0, "fetch clears with pin low");
    pin(0);
    $display("edge test done");
    wr(SC, 32'h2);
    pin(1);
    pin(0);
    chkb(irq_request, 0, "masked");
    rdc(SC, 32'ha, "flag under mask");
    wr(SC, 32'h0);
    cyc(1);
    chkb(irq_request, 1, "unmasked");
    wr(SC, 32'h4);
    cyc(1);
    chkb(irq_request, 0, "software ack");
    pin(1);
    chkb(irq_request, 1, "edge after ack");
    pin(0);
    wr(SC, 32'h4);
    $display("mask test done");
    wr(SC, 32'h1);
    pin(1);
    vfa();
    chkb(irq_request, 1, "level held low");
    chkb(branch_pin_level, 0, "branch sees low");
    pin(0);
    chkb(irq_request, 0, "ack then high");
    pin(1);
    pin(0);
    chkb(irq_request, 1, "high before ack");
    // service routine masks while level triggered
    wr(SC, 32'h7);
    cyc(1);
    chkb(irq_request, 0, "high then ack");
    rdc(SC, 32'h3, "flag after high then ack");
    wr(SC, 32'h4);
    wr(CF, 32'h0);
    pin(1);
    chkb(branch_pin_level, 1, "branch when off");
    chkb(irq_request, 0, "no request when off");
    pin(0);
    wr(CF, 32'h1);
    $display("level test done");
    pin(1);
    pin(0);
    @(posedge sys_clk) break_state <= 1'b1;
    wr(SC, 32'h4);
    cyc(1);
    chkb(irq_request, 1, "break protects");
    @(posedge sys_clk) break_clear_enable <= 1'b1;
    wr(SC, 32'h4);
    cyc(1);
    chkb(irq_request, 0, "break clear");
    @(posedge sys_clk) break_state <= 1'b0;
    cyc(2);
    chkb(irq_request, 0, "clear persists");
    $display("break test done");
    wr(SC, 32'h1);
    pin(1);
    chkb(irq_request, 1, "level set");
    @(posedge sys_clk) rst <= 1'b1;
    cyc(3);
    @(posedge sys_clk) rst <= 1'b0;
    cyc(2);
    chkb(irq_request, 0, "reset clears");
    rdc(SC, 32'h0, "mode cleared");
    wr(CF, 32'h1);
    cyc(2);
    chkb(irq_request, 0, "low pin after reset");
    $display("reset test done");
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
